// ===== src/mtp_pkg.sv
package mtp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h87;
  localparam logic [7:0] BREAKPOINT_STATUS_ADDR = 8'hbd;
  localparam logic [7:0] TICK_RELOAD_ADDR       = 8'hf6;
  localparam logic [7:0] BKPT_LOW_ADDR          = 8'hbe;
  localparam logic [7:0] BKPT_HIGH_ADDR         = 8'hcf;
  localparam logic [7:0] BKPT_UNLOCK_VALUE      = 8'h55;

  // ==========================================================================
  // Power control fields and register reset values
  localparam int         IDLE_BIT_POS           = 0;
  localparam int         DOUBLE_BAUD_POS        = 7;
  localparam logic [7:0] POWER_CONTROL_WMASK    = 8'h8d;
  localparam logic [7:0] POWER_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] TICK_RELOAD_RESET      = 8'h00;
  localparam logic [7:0] BREAKPOINT_STATUS_RESET = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int TICK_PERIOD_US  = 10;
  localparam int TICK_PRESCALE   = TICK_PERIOD_US * CLK_FREQ_MHZ;

endpackage

// ===== src/mtp_tick_if.sv
`timescale 1ns/1ps
interface mtp_tick_if;
  logic       load;
  logic [7:0] load_value;
  logic       tick_en;
  logic       expire;
  modport ctrl (output load, output load_value, output tick_en, input expire);
  modport cnt  (input load, input load_value, input tick_en, output expire);
endinterface

// ===== src/mtp_tick_counter.sv
`timescale 1ns/1ps
module mtp_tick_counter
  import mtp_pkg::*;
(
  // Clock and reset
  input wire logic  core_clk,
  input wire logic  rst,
  // Control
  mtp_tick_if.cnt   tif
);

  logic [7:0] count;
  logic [7:0] reload;
  wire        at_zero = (count == 8'h01);
  wire        armed   = (reload != 8'h00);

  // ==========================================================================
  // Down counter
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count  <= 8'h00;
      reload <= 8'h00;
    end
    else if (tif.load)
    begin
      count  <= tif.load_value;
      reload <= tif.load_value;
    end
    else if (tif.tick_en && armed)
    begin
      // Count at one reloads instead of stepping to zero, so the period is reload ticks.
      count <= at_zero ? reload : count - 8'h01;
    end
  end

  assign tif.expire = tif.tick_en && armed && at_zero && !tif.load;

endmodule

// ===== src/mtp_top.sv
`timescale 1ns/1ps
module mtp_top
  import mtp_pkg::*;
#(
  parameter int PRESCALE = TICK_PRESCALE
)
(
  // Clock and resets
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       watchdog_reset,
  input  wire logic       bus_reset,
  input  wire logic       function_reset_connect,
  // Special register bus from the core
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  // Interrupt context
  input  wire logic       tick_interrupt_enable,
  input  wire logic       enabled_irq_active,
  output logic            tick_interrupt_line,
  // Core events
  input  wire logic       long_jump_app,
  input  wire logic       long_jump_monitor,
  // Status outputs
  output logic            idle_request_bit,
  output logic      [1:0] general_purpose_flags,
  output logic            double_baud_select,
  output logic            bkpt_write_allowed
);

  // ==========================================================================
  // Reset qualification
  wire soft_clear = watchdog_reset || (bus_reset && function_reset_connect);

  // ==========================================================================
  // Address decode
  wire sel_power  = (sfr_addr == POWER_CONTROL_ADDR);
  wire sel_bkstat = (sfr_addr == BREAKPOINT_STATUS_ADDR);
  wire sel_reload = (sfr_addr == TICK_RELOAD_ADDR);
  wire sel_bkpt   = (sfr_addr >= BKPT_LOW_ADDR) && (sfr_addr <= BKPT_HIGH_ADDR);
  wire wr_power   = sfr_wr && sel_power;
  wire wr_bkstat  = sfr_wr && sel_bkstat;
  wire wr_reload  = sfr_wr && sel_reload;

  logic [7:0] power_control;
  logic [7:0] breakpoint_status;
  logic [7:0] tick_reload_value;
  logic       bkpt_locked;

  // ==========================================================================
  // Time base prescaler
  logic [$clog2(PRESCALE)-1:0] pre_cnt;
  wire pre_wrap = (pre_cnt == ($clog2(PRESCALE))'(PRESCALE - 1));

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_clear)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_wrap ? '0 : pre_cnt + 1'b1;
  end

  // ==========================================================================
  // Tick counter
  mtp_tick_if tif ();
  assign tif.load       = wr_reload || soft_clear || rst;
  assign tif.load_value = (soft_clear || rst) ? TICK_RELOAD_RESET : sfr_wdata;
  assign tif.tick_en    = pre_wrap;

  mtp_tick_counter u_cnt (
    .core_clk (core_clk),
    .rst      (rst),
    .tif      (tif)
  );

  // Interrupt only reaches the core when enabled, pulse is one clock wide.
  wire next_tick_irq = tif.expire && tick_interrupt_enable;

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_clear)
    begin
      tick_reload_value   <= TICK_RELOAD_RESET;
      power_control       <= POWER_CONTROL_RESET;
      tick_interrupt_line <= 1'b0;
    end
    else
    begin
      tick_interrupt_line <= next_tick_irq;
      if (wr_reload)
        tick_reload_value <= sfr_wdata;
      if (wr_power)
        power_control <= sfr_wdata & POWER_CONTROL_WMASK;
      // Interrupt wake beats a same-cycle idle write so the core never sleeps through it.
      if (enabled_irq_active || next_tick_irq)
        power_control[IDLE_BIT_POS] <= 1'b0;
    end
  end

  // Breakpoint status and lock. Power-up reset leaves the monitor unlocked.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      breakpoint_status <= BREAKPOINT_STATUS_RESET;
      bkpt_locked       <= 1'b0;
    end
    else
    begin
      if (wr_bkstat)
        breakpoint_status <= sfr_wdata;
      if (long_jump_monitor || (wr_bkstat && sfr_wdata == BKPT_UNLOCK_VALUE))
        bkpt_locked <= 1'b0;
      else if (long_jump_app)
        bkpt_locked <= 1'b1;
    end
  end

  // ==========================================================================
  // Read path
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= sel_power  ? power_control :
                   sel_bkstat ? breakpoint_status :
                   sel_reload ? tick_reload_value : 8'h00;
  end

  assign sfr_hit               = sel_power || sel_bkstat || sel_reload;
  assign idle_request_bit      = power_control[IDLE_BIT_POS];
  assign general_purpose_flags = power_control[3:2];
  assign double_baud_select    = power_control[DOUBLE_BAUD_POS];
  assign bkpt_write_allowed    = !(bkpt_locked && sfr_wr && sel_bkpt);

  // ==========================================================================
  // Checks
  a_irq_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    tick_interrupt_line |=> !tick_interrupt_line)
    else $error("tick pulse longer than one cycle");
  a_irq_needs_en: assert property (@(posedge core_clk) disable iff (rst)
    tick_interrupt_line |-> $past(tick_interrupt_enable) && $past(tick_reload_value) != 8'h00)
    else $error("tick pulse while disabled");
  a_reload_reads: assert property (@(posedge core_clk) disable iff (rst || soft_clear)
    wr_reload |=> tick_reload_value == $past(sfr_wdata))
    else $error("reload write lost");
  a_soft_clear: assert property (@(posedge core_clk) disable iff (rst)
    soft_clear |=> power_control == 8'h00 && tick_reload_value == 8'h00)
    else $error("qualified reset did not clear");
  a_power_rsv: assert property (@(posedge core_clk) disable iff (rst)
    (power_control & ~POWER_CONTROL_WMASK) == 8'h00)
    else $error("reserved power bits set");
  a_idle_clear: assert property (@(posedge core_clk) disable iff (rst || soft_clear)
    enabled_irq_active |=> !idle_request_bit)
    else $error("idle not cleared by interrupt");
  a_bkpt_lock: assert property (@(posedge core_clk) disable iff (rst)
    long_jump_app && !long_jump_monitor && !wr_bkstat |=> bkpt_locked)
    else $error("breakpoint lock not set");
  a_bkpt_unlock: assert property (@(posedge core_clk) disable iff (rst)
    wr_bkstat && sfr_wdata == BKPT_UNLOCK_VALUE |=> !bkpt_locked)
    else $error("breakpoint unlock failed");

endmodule

// ===== verif/mtp_core_model.sv
`timescale 1ns/1ps
module mtp_core_model
(
  // Clock
  input  wire logic       core_clk,
  // Special register bus
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // ==========================================================================
  // Access tasks
  // A released bus shows inverted values so that stale data never passes.
  task automatic drop();
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
    // One idle cycle keeps the next request from reassigning the strobe in this step.
    @(negedge core_clk);
  endtask
  // Callers only write mapped or breakpoint addresses, never reserved ones.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'hd1 && a <= 8'hdf)
      return;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    drop();
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    drop();
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  import mtp_pkg::*;
  localparam int PS = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic watchdog_reset, bus_reset, function_reset_connect, tick_interrupt_enable;
  logic enabled_irq_active, long_jump_app, long_jump_monitor;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic sfr_wr, sfr_rd, sfr_hit, tick_interrupt_line, idle_request_bit;
  logic double_baud_select, bkpt_write_allowed;
  logic [1:0] general_purpose_flags;
  logic [7:0] exp_q[$];
  logic [7:0] pv[2] = '{8'h01, 8'h03};
  logic exp_allow = 1'b1;
  int err_total = 0;
  int n_compared = 0;
  int seed = 32'h4ae12326;
  int n;
  wire hit_exp = sfr_addr inside {POWER_CONTROL_ADDR, BREAKPOINT_STATUS_ADDR, TICK_RELOAD_ADDR};
  always #5 core_clk = ~core_clk;
  mtp_core_model core (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd));
  mtp_top #(.PRESCALE(PS)) dut (.core_clk(core_clk), .rst(rst),
    .watchdog_reset(watchdog_reset), .bus_reset(bus_reset),
    .function_reset_connect(function_reset_connect), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .tick_interrupt_enable(tick_interrupt_enable),
    .enabled_irq_active(enabled_irq_active), .tick_interrupt_line(tick_interrupt_line),
    .long_jump_app(long_jump_app), .long_jump_monitor(long_jump_monitor),
    .idle_request_bit(idle_request_bit), .general_purpose_flags(general_purpose_flags),
    .double_baud_select(double_baud_select), .bkpt_write_allowed(bkpt_write_allowed));
  // ==========================================================================
  // Checking
  task automatic final_report();
    $display("TB: compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk)
  begin
    if (sfr_wr === 1'b1 && sfr_addr >= BKPT_LOW_ADDR && sfr_addr <= BKPT_HIGH_ADDR)
      check({7'h00, bkpt_write_allowed}, {7'h00, exp_allow});
    if (sfr_rd === 1'b1)
    begin
      check({7'h00, sfr_hit}, {7'h00, hit_exp});
      @(negedge core_clk);
      check(sfr_rdata, exp_q.pop_front());
    end
  end
  // ==========================================================================
  // Stimulus helpers
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    core.rd(a);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic wait_irq(input int lim, output int c);
    c = 0;
    while (tick_interrupt_line !== 1'b1 && c < lim)
    begin
      @(negedge core_clk);
      c++;
    end
    if (c >= lim)
    begin
      check(8'h00, 8'h01);
      final_report();
    end
  endtask
  task automatic quiet(input int k);
    repeat (k) @(negedge core_clk) check({7'h00, tick_interrupt_line}, 8'h00);
  endtask
  task automatic reset_check(ref logic s, input logic [7:0] et, input logic [7:0] ep);
    core.wr(TICK_RELOAD_ADDR, 8'h22);
    core.wr(POWER_CONTROL_ADDR, 8'h84);
    pulse(s);
    rd(TICK_RELOAD_ADDR, et);
    rd(POWER_CONTROL_ADDR, ep);
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    {watchdog_reset, bus_reset, function_reset_connect, tick_interrupt_enable} = 4'h0;
    {enabled_irq_active, long_jump_app, long_jump_monitor} = 3'h0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    rd(POWER_CONTROL_ADDR, POWER_CONTROL_RESET);
    rd(TICK_RELOAD_ADDR, TICK_RELOAD_RESET);
    rd(8'h90, 8'h00);
    core.wr(POWER_CONTROL_ADDR, 8'hff);
    rd(POWER_CONTROL_ADDR, 8'h8d);
    check({idle_request_bit, general_purpose_flags, double_baud_select, 4'h0}, 8'hf0);
    pulse(enabled_irq_active);
    rd(POWER_CONTROL_ADDR, 8'h8c);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      core.wr(TICK_RELOAD_ADDR, v);
      rd(TICK_RELOAD_ADDR, v);
    end
    tick_interrupt_enable = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      core.wr(TICK_RELOAD_ADDR, pv[i]);
      wait_irq(2000, n);
      @(negedge core_clk);
      check({7'h00, tick_interrupt_line}, 8'h00);
      wait_irq(2000, n);
      check(8'(n + 1), 8'(pv[i] * PS));
    end
    core.wr(TICK_RELOAD_ADDR, 8'h06);
    wait_irq(40, n);
    check(8'(n >= 18 && n <= 26), 8'h01);
    core.wr(TICK_RELOAD_ADDR, 8'h00);
    quiet(40);
    tick_interrupt_enable = 1'b0;
    core.wr(TICK_RELOAD_ADDR, 8'h02);
    quiet(40);
    reset_check(bus_reset, 8'h22, 8'h84);
    function_reset_connect = 1'b1;
    reset_check(bus_reset, 8'h00, 8'h00);
    reset_check(watchdog_reset, 8'h00, 8'h00);
    core.wr(8'hbe, 8'h12);
    pulse(long_jump_app);
    exp_allow = 1'b0;
    core.wr(8'hbe, 8'h34);
    core.wr(BREAKPOINT_STATUS_ADDR, BKPT_UNLOCK_VALUE);
    exp_allow = 1'b1;
    core.wr(8'hbf, 8'h56);
    rd(BREAKPOINT_STATUS_ADDR, BKPT_UNLOCK_VALUE);
    pulse(long_jump_app);
    exp_allow = 1'b0;
    core.wr(8'hcf, 8'h01);
    pulse(long_jump_monitor);
    exp_allow = 1'b1;
    core.wr(8'hcf, 8'h02);
    repeat (2) @(negedge core_clk);
    final_report();
  end
endmodule
